// ---- verilog/afe_pkg.sv ----
// afe_pkg: shared constants and types of the front-end configuration register bank
`default_nettype none
package afe_pkg;

  // ************************************************************
  // serial frame layout
  // ************************************************************
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 10;
  localparam int          FRAME_BITS  = ADDR_W + DATA_W;   // address first, msb first
  localparam int          NUM_CHAN    = 3;
  localparam logic [3:0]  FRAME_LEN   = 4'he;

  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [3:0]  ADDR_RED_GAIN_CODE     = 4'h0;
  localparam logic [3:0]  ADDR_GREEN_GAIN_CODE   = 4'h1;
  localparam logic [3:0]  ADDR_BLUE_GAIN_CODE    = 4'h2;
  localparam logic [3:0]  ADDR_RED_OFFSET_TRIM   = 4'h3;
  localparam logic [3:0]  ADDR_GREEN_OFFSET_TRIM = 4'h4;
  localparam logic [3:0]  ADDR_BLUE_OFFSET_TRIM  = 4'h5;
  localparam logic [3:0]  ADDR_MODE_ONE          = 4'h6;
  localparam logic [3:0]  ADDR_MODE_TWO          = 4'h7;

  // ************************************************************
  // field positions inside the 10-bit data word
  // ************************************************************
  localparam int GAIN_MSB     = 9;   // gain code sits in bits 9..1, bit 0 ignored
  localparam int GAIN_LSB     = 1;
  localparam int COARSE_MSB   = 9;
  localparam int COARSE_LSB   = 8;
  localparam int FINE_MSB     = 7;
  localparam int FINE_LSB     = 0;
  localparam int M1_MUX_MSB   = 9;
  localparam int M1_MUX_LSB   = 7;
  localparam int M1_GS_BIT    = 6;
  localparam int M1_LC_BIT    = 5;
  localparam int M1_CIS_BIT   = 4;
  localparam int M1_NIB_BIT   = 3;
  localparam int M1_CLV_MSB   = 2;
  localparam int M1_CLV_LSB   = 0;
  localparam int M2_PD_BIT    = 9;
  localparam int M2_OE_BIT    = 8;
  localparam int M2_LPOL_BIT  = 3;
  localparam int M2_APOL_BIT  = 2;
  localparam int M2_BPOL_BIT  = 1;
  localparam int M2_VPOL_BIT  = 0;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [8:0]  GAIN_RESET    = 9'h000;
  localparam logic [1:0]  COARSE_ZERO   = 2'h0;    // zero coarse offset
  localparam logic [7:0]  FINE_ZERO     = 8'h00;   // zero fine offset
  localparam logic [2:0]  MUX_RESET     = 3'h0;    // three-channel
  localparam logic [2:0]  CLAMP_RESET   = 3'h6;
  localparam logic        NIBBLE_RESET  = 1'b1;
  localparam logic        GS_RESET      = 1'b0;    // low gain range
  localparam logic        LC_RESET      = 1'b0;    // line clamp off
  localparam logic        CIS_RESET     = 1'b0;    // ccd imager
  localparam logic        DRIVE_RESET   = 1'b1;    // output bus driven

  // input mux codes
  localparam logic [2:0]  MUX_RGB = 3'h0;
  localparam logic [2:0]  MUX_R   = 3'h1;
  localparam logic [2:0]  MUX_G   = 3'h2;
  localparam logic [2:0]  MUX_B   = 3'h3;
  localparam logic [2:0]  MUX_RG  = 3'h4;
  localparam logic [2:0]  MUX_GR  = 3'h5;
  localparam logic [2:0]  MUX_GB  = 3'h6;
  localparam logic [2:0]  MUX_BR  = 3'h7;

  // channels in use per mux code, {blue, green, red}
  localparam logic [2:0]  USE_RGB = 3'h7;
  localparam logic [2:0]  USE_R   = 3'h1;
  localparam logic [2:0]  USE_G   = 3'h2;
  localparam logic [2:0]  USE_B   = 3'h4;
  localparam logic [2:0]  USE_RG  = 3'h3;
  localparam logic [2:0]  USE_GB  = 3'h6;
  localparam logic [2:0]  USE_BR  = 3'h5;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [8:0] gain_code;
    logic [1:0] coarse_offset_field;
    logic [7:0] fine_offset_field;
  } afe_chan_cfg_t;

  typedef struct packed {
    logic [2:0] input_mux_select;
    logic       gain_range_select;
    logic       line_clamp_enable;
    logic       imager_type_select;  // 0 ccd, 1 cis
    logic       nibble_output;       // 0 byte, 1 nibble
    logic [2:0] clamp_level_select;
  } afe_mode_one_t;

  typedef struct packed {
    logic power_down_control;
    logic output_tristate;
    logic line_clamp_invert;
    logic adc_clock_invert;
    logic black_sample_invert;
    logic video_sample_invert;
  } afe_mode_two_t;

endpackage : afe_pkg
`default_nettype wire

// ---- verilog/afe_ser_rx.sv ----
// afe_ser_rx: three-pin serial write port, synchronised to mclk
`timescale 1ns/1ps
`default_nettype none
module afe_ser_rx
  import afe_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              ser_clk_pin,
  input  wire logic              ser_data_pin,
  input  wire logic              ser_load_b_pin,
  output var  logic              frame_valid,
  output var  logic [ADDR_W-1:0] frame_addr,
  output var  logic [DATA_W-1:0] frame_data
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [2:0] sync_a;   // first stage, read only by sync_b
  logic [2:0] sync_b;
  logic [2:0] sync_c;   // delayed copy for edge detection

  // three pins, two flops each, plus one more for edges
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sync_a <= 3'h7;
      sync_b <= 3'h7;
      sync_c <= 3'h7;
    end else begin
      sync_a <= {ser_load_b_pin, ser_data_pin, ser_clk_pin};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // ************************************************************
  // shift and frame detection
  // ************************************************************
  logic                  clk_rise;
  logic                  load_rise;
  logic                  load_b;
  logic [FRAME_BITS-1:0] shift;
  logic [3:0]            count;
  logic                  next_valid;

  assign load_b     = sync_b[2];
  assign clk_rise   = sync_b[0] & ~sync_c[0] & ~load_b;
  assign load_rise  = sync_b[2] & ~sync_c[2];
  // wrong bit counts are dropped so a torn frame never lands in a register
  assign next_valid = load_rise & (count == FRAME_LEN);

  // shift on clock rise while load is low; count saturates
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      shift <= '0;
      count <= 4'h0;
    end else if (load_b) begin
      count <= 4'h0;
    end else if (clk_rise) begin
      shift <= {shift[FRAME_BITS-2:0], sync_b[1]};
      count <= (count == 4'hf) ? count : count + 4'h1;
    end
  end

  // frame word latched at load release
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      frame_valid <= 1'b0;
      frame_addr  <= '0;
      frame_data  <= '0;
    end else begin
      frame_valid <= next_valid;
      if (next_valid) begin
        frame_addr <= shift[FRAME_BITS-1:DATA_W];
        frame_data <= shift[DATA_W-1:0];
      end
    end
  end

endmodule : afe_ser_rx
`default_nettype wire

// ---- verilog/afe_cfg_regs.sv ----
// afe_cfg_regs: gain, offset and mode registers of the three-channel front end
`timescale 1ns/1ps
`default_nettype none

module afe_cfg_regs
  import afe_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          rst_b,
  input  wire logic          ser_clk_pin,
  input  wire logic          ser_data_pin,
  input  wire logic          ser_load_b_pin,
  output var  afe_chan_cfg_t chan_cfg [NUM_CHAN],
  output var  afe_mode_one_t mode_one,
  output var  afe_mode_two_t mode_two,
  output var  logic [2:0]    chan_active,
  output var  logic          high_gain_range,
  output var  logic          data_bus_drive
);

  // ************************************************************
  // serial write port
  // ************************************************************
  logic              wr_valid;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;

  // the only path into the registers
  afe_ser_rx u_ser_rx (
    .mclk           (mclk),
    .rst_b          (rst_b),
    .ser_clk_pin    (ser_clk_pin),
    .ser_data_pin   (ser_data_pin),
    .ser_load_b_pin (ser_load_b_pin),
    .frame_valid    (wr_valid),
    .frame_addr     (wr_addr),
    .frame_data     (wr_data)
  );

  // ************************************************************
  // address decode
  // ************************************************************
  logic       wr_mode_one;
  logic       wr_mode_two;
  logic [8:0] wr_gain_field;
  logic [1:0] wr_coarse_field;
  logic [7:0] wr_fine_field;

  // delay, test and reset addresses are not held here and are ignored;
  // an unmapped address is dropped, never folded onto a held register
  assign wr_mode_one = wr_valid & (wr_addr == ADDR_MODE_ONE);
  assign wr_mode_two = wr_valid & (wr_addr == ADDR_MODE_TWO);

  // field slices of the incoming word, shared by all three channels
  assign wr_gain_field   = wr_data[GAIN_MSB:GAIN_LSB];
  assign wr_coarse_field = wr_data[COARSE_MSB:COARSE_LSB];
  assign wr_fine_field   = wr_data[FINE_MSB:FINE_LSB];

  // ************************************************************
  // per-channel gain and offset registers
  // ************************************************************
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      logic wr_gain;
      logic wr_offset;

      // each channel decodes its own pair of addresses;
      // both register groups run red, green, blue, so ch steps both bases
      assign wr_gain   = wr_valid &
                         (wr_addr == ADDR_RED_GAIN_CODE + ADDR_W'(ch));
      assign wr_offset = wr_valid &
                         (wr_addr == ADDR_RED_OFFSET_TRIM + ADDR_W'(ch));

      // gain code; bit 0 of the word is dropped on purpose
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          chan_cfg[ch].gain_code <= GAIN_RESET;
        end else if (wr_gain) begin
          chan_cfg[ch].gain_code <= wr_gain_field;
        end
      end

      // coarse and fine trims pass straight through; the sign convention
      // lives in the analog stage so the code is not remapped here
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          chan_cfg[ch].coarse_offset_field <= COARSE_ZERO;
          chan_cfg[ch].fine_offset_field   <= FINE_ZERO;
        end else if (wr_offset) begin
          chan_cfg[ch].coarse_offset_field <= wr_coarse_field;
          chan_cfg[ch].fine_offset_field   <= wr_fine_field;
        end
      end
    end
  endgenerate

  // ************************************************************
  // mode one
  // ************************************************************
  afe_mode_one_t next_mode_one;

  // field unpack of the incoming word;
  // fields are stored as written, their meaning is decoded in the analog stage
  assign next_mode_one = '{
    input_mux_select:   wr_data[M1_MUX_MSB:M1_MUX_LSB],
    gain_range_select:  wr_data[M1_GS_BIT],
    line_clamp_enable:  wr_data[M1_LC_BIT],
    imager_type_select: wr_data[M1_CIS_BIT],
    nibble_output:      wr_data[M1_NIB_BIT],
    clamp_level_select: wr_data[M1_CLV_MSB:M1_CLV_LSB]
  };

  // defaults: three-channel, low range, ccd, nibble, clamp code six
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mode_one <= '{
        input_mux_select:   MUX_RESET,
        gain_range_select:  GS_RESET,
        line_clamp_enable:  LC_RESET,
        imager_type_select: CIS_RESET,
        nibble_output:      NIBBLE_RESET,
        clamp_level_select: CLAMP_RESET
      };
    end else if (wr_mode_one) begin
      mode_one <= next_mode_one;
    end
  end

  // ************************************************************
  // mode two
  // ************************************************************
  afe_mode_two_t next_mode_two;

  // bits 7..4 are unused and simply not stored;
  // the output enable bit is a tristate request: a one floats the bus
  assign next_mode_two = '{
    power_down_control:  wr_data[M2_PD_BIT],
    output_tristate:     wr_data[M2_OE_BIT],
    line_clamp_invert:   wr_data[M2_LPOL_BIT],
    adc_clock_invert:    wr_data[M2_APOL_BIT],
    black_sample_invert: wr_data[M2_BPOL_BIT],
    video_sample_invert: wr_data[M2_VPOL_BIT]
  };

  // power down leaves every register intact; the port keeps running
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mode_two <= '0;
    end else if (wr_mode_two) begin
      mode_two <= next_mode_two;
    end
  end

  // ************************************************************
  // derived controls for the analog side
  // ************************************************************
  logic [2:0] next_active;
  logic [2:0] next_mux;
  logic       next_range;
  logic       next_pd;
  logic       next_tristate;
  logic       next_drive;

  // mux code in force after this edge, so the mask moves with mode one
  assign next_mux = wr_mode_one ? next_mode_one.input_mux_select
                                : mode_one.input_mux_select;

  // channel mask {blue, green, red}; unused channels may be powered down
  always_comb begin
    next_active = USE_RGB;
    case (next_mux)
      MUX_RGB: next_active = USE_RGB;
      MUX_R:   next_active = USE_R;
      MUX_G:   next_active = USE_G;
      MUX_B:   next_active = USE_B;
      MUX_RG:  next_active = USE_RG;
      MUX_GR:  next_active = USE_RG;
      MUX_GB:  next_active = USE_GB;
      MUX_BR:  next_active = USE_BR;
      default: next_active = USE_RGB;
    endcase
  end

  // gain scale follows the range bit together with the code registers
  assign next_range = wr_mode_one ? next_mode_one.gain_range_select
                                  : mode_one.gain_range_select;

  // power-down and tristate bits in force after this edge
  assign next_pd       = wr_mode_two ? next_mode_two.power_down_control
                                     : mode_two.power_down_control;
  assign next_tristate = wr_mode_two ? next_mode_two.output_tristate
                                     : mode_two.output_tristate;
  // bus driven only when enabled and not powered down; power down wins so
  // a sleeping part never fights another device sharing the data bus
  assign next_drive = ~(next_tristate | next_pd);

  // registered so every output leaves straight from a flop, in step with the mode regs;
  // one flop each keeps the analog controls free of decode glitches
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      chan_active     <= USE_RGB;
      high_gain_range <= GS_RESET;
      data_bus_drive  <= DRIVE_RESET;
    end else begin
      chan_active     <= next_active;
      high_gain_range <= next_range;
      data_bus_drive  <= next_drive;
    end
  end

endmodule : afe_cfg_regs
`default_nettype wire

// ---- verification/afe_host_model.sv ----
// afe_host_model: serial host that loads the front-end registers
`timescale 1ns/1ps
`default_nettype none
module afe_host_model (
  input  wire logic mclk,
  output var  logic ser_clk_pin,
  output var  logic ser_data_pin,
  output var  logic ser_load_b_pin
);
  // idle pins: strobe high, serial clock parked low
  initial begin
    ser_clk_pin    = 1'b0;
    ser_data_pin   = 1'b0;
    ser_load_b_pin = 1'b1;
  end

  // ********************
  // one frame, msb first
  // ********************
  // hold paces each clock phase in mclk cycles, 3 is the fastest allowed
  task automatic send(input logic [14:0] word, input int nbits, input int hold);
    @(posedge mclk) ser_load_b_pin <= 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      @(posedge mclk) ser_data_pin <= word[i];
      repeat (hold) @(posedge mclk);
      ser_clk_pin <= 1'b1;
      repeat (hold) @(posedge mclk);
      ser_clk_pin <= 1'b0;
    end
    repeat (hold) @(posedge mclk);
    ser_load_b_pin <= 1'b1;
    // no pull on the data line, so a released line must not keep its value
    ser_data_pin   <= ~ser_data_pin;
    repeat (3) @(posedge mclk);
  endtask : send
endmodule : afe_host_model
`default_nettype wire

// ---- verification/afe_cfg_regs_asserts.sv ----
// afe_cfg_regs_asserts: port-level checks of the register bank
`timescale 1ns/1ps
`default_nettype none
module afe_cfg_regs_checker
  import afe_pkg::*;
(
  input wire logic          mclk,
  input wire logic          rst_b,
  input wire logic          ser_clk_pin,
  input wire logic          ser_data_pin,
  input wire logic          ser_load_b_pin,
  input wire afe_chan_cfg_t chan_cfg [NUM_CHAN],
  input wire afe_mode_one_t mode_one,
  input wire afe_mode_two_t mode_two,
  input wire logic [2:0]    chan_active,
  input wire logic          high_gain_range,
  input wire logic          data_bus_drive
);
  localparam logic [23:0] ACT_TBL = 24'hb9_b88f;  // {b,g,r} in use per mux code
  wire logic [72:0] all_q;
  logic [3:0]       load_age;

  // every register output in one vector, for change detection
  assign all_q = {chan_cfg[0], chan_cfg[1], chan_cfg[2], mode_one, mode_two};

  // cycles since the strobe was last low; saturates so it never wraps
  always_ff @(posedge mclk) begin
    if (!rst_b) load_age <= 4'hf;
    else if (!ser_load_b_pin) load_age <= 4'h0;
    else if (load_age != 4'hf) load_age <= load_age + 4'h1;
  end

  // ********************
  // assertions
  // ********************
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_offset_reset: assert property ($rose(rst_b) |->
    chan_cfg[0][9:0] == 10'h000 && chan_cfg[1][9:0] == 10'h000 && chan_cfg[2][9:0] == 10'h000)
    else $error("offset not zero after reset");
  a_mode_reset: assert property ($rose(rst_b) |-> mode_two == '0 &&
    mode_one == {MUX_RESET, 3'h0, NIBBLE_RESET, CLAMP_RESET})
    else $error("mode registers wrong after reset");
  a_range_copy: assert property (high_gain_range == mode_one.gain_range_select)
    else $error("gain range flag differs from mode one");
  a_bus_drive: assert property (data_bus_drive ==
    !(mode_two.power_down_control || mode_two.output_tristate))
    else $error("bus drive disagrees with mode two");
  a_mux_active: assert property (chan_active == ACT_TBL[mode_one.input_mux_select*3 +: 3])
    else $error("active channels disagree with mux code");
  a_write_latency: assert property ($changed(all_q) |-> load_age <= 4'h7)
    else $error("register changed without a recent frame");
  a_hold_in_frame: assert property (!ser_load_b_pin [*8] |-> $stable(all_q))
    else $error("register changed inside a frame");
  a_chan_apart: assert property ($changed(chan_cfg[0]) |-> $stable(chan_cfg[1]) &&
    $stable(chan_cfg[2]) && $stable(mode_one))
    else $error("red write disturbed another register");
endmodule : afe_cfg_regs_checker

bind afe_cfg_regs afe_cfg_regs_checker i_chk (
  .mclk(mclk), .rst_b(rst_b), .ser_clk_pin(ser_clk_pin), .ser_data_pin(ser_data_pin),
  .ser_load_b_pin(ser_load_b_pin), .chan_cfg(chan_cfg), .mode_one(mode_one),
  .mode_two(mode_two), .chan_active(chan_active), .high_gain_range(high_gain_range),
  .data_bus_drive(data_bus_drive)
);
`default_nettype wire

// ---- verification/tb.sv ----
// tb: self-checking bench for the front-end register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import afe_pkg::*;
  localparam logic [23:0] ACT_TBL  = 24'hb9_b88f;   // {b,g,r} in use per mux code
  localparam logic [31:0] FINE_TBL = 32'h807f_ff00; // fine codes: zero, ends, middle
  logic             mclk = 1'b0;
  logic             rst_b = 1'b0;
  wire logic        ser_clk_pin;
  wire logic        ser_data_pin;
  wire logic        ser_load_b_pin;
  afe_chan_cfg_t    chan_cfg [NUM_CHAN];
  afe_mode_one_t    mode_one;
  afe_mode_two_t    mode_two;
  logic [2:0]       chan_active;
  logic             high_gain_range;
  logic             data_bus_drive;
  wire logic [77:0] got_snap;
  logic [77:0]      exp_q [$];
  logic [77:0]      last_exp;
  logic [77:0]      prev_snap;
  logic             mon_on = 1'b0;
  afe_chan_cfg_t    e_ch [NUM_CHAN];
  afe_mode_one_t    e_m1;
  afe_mode_two_t    e_m2;
  int               errors = 0;
  int               checks_done = 0;
  integer           seed = 32'h945f_a5e0;

  always #4 mclk = ~mclk;

  afe_host_model i_host (.mclk(mclk), .ser_clk_pin(ser_clk_pin), .ser_data_pin(ser_data_pin),
    .ser_load_b_pin(ser_load_b_pin));
  afe_cfg_regs i_dut (.mclk(mclk), .rst_b(rst_b), .ser_clk_pin(ser_clk_pin),
    .ser_data_pin(ser_data_pin), .ser_load_b_pin(ser_load_b_pin), .chan_cfg(chan_cfg),
    .mode_one(mode_one), .mode_two(mode_two), .chan_active(chan_active),
    .high_gain_range(high_gain_range), .data_bus_drive(data_bus_drive));

  // all outputs in one word; a change of it is one result
  assign got_snap = {chan_cfg[0], chan_cfg[1], chan_cfg[2], mode_one, mode_two, chan_active,
    high_gain_range, data_bus_drive};

  // ********************
  // expected-state model
  // ********************
  function automatic logic [77:0] exp_snap();
    return {e_ch[0], e_ch[1], e_ch[2], e_m1, e_m2, ACT_TBL[e_m1.input_mux_select*3 +: 3],
      e_m1.gain_range_select, ~(e_m2.power_down_control | e_m2.output_tristate)};
  endfunction : exp_snap

  task automatic rst_exp();
    for (int c = 0; c < NUM_CHAN; c++) e_ch[c] = {GAIN_RESET, COARSE_ZERO, FINE_ZERO};
    e_m1 = {MUX_RESET, 3'h0, NIBBLE_RESET, CLAMP_RESET};
    e_m2 = '0;
  endtask : rst_exp

  // a write that leaves every output as it was yields no note
  task automatic note();
    if (exp_snap() !== last_exp) begin
      last_exp = exp_snap();
      exp_q.push_back(last_exp);
    end
  endtask : note

  task automatic chk(input logic [77:0] e, input logic [77:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t outputs %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // bounded wait for pending notes, then quiet time to catch stray changes
  task automatic drain();
    for (int n = 0; n < 40 && exp_q.size() != 0; n++) @(posedge mclk);
    if (exp_q.size() != 0) begin
      errors++;
      $display("[ERR] %0t no register change seen", $time);
      print_verdict();
    end
    repeat (8) @(posedge mclk);
  endtask : drain

  task automatic wr(input logic [3:0] a, input logic [9:0] d, input int hold);
    if (a < 4'h3) e_ch[a].gain_code = d[9:1];
    else if (a < 4'h6) e_ch[a - 4'h3][9:0] = d;
    else if (a == 4'h6) e_m1 = d;
    else e_m2 = {d[9:8], d[3:0]};
    note();
    i_host.send({1'b0, a, d}, 14, hold);
    drain();
  endtask : wr

  // result watcher: every output change consumes the oldest note
  always @(posedge mclk) begin
    if (mon_on && got_snap !== prev_snap) begin
      prev_snap <= got_snap;
      if (exp_q.size() == 0) begin
        errors++;
        $display("[ERR] %0t unexpected output change", $time);
      end
      else chk(exp_q.pop_front(), got_snap);
    end
  end

  // ********************
  // main sequence
  // ********************
  initial begin
    repeat (10) @(posedge mclk);
    rst_exp();
    last_exp = exp_snap();
    chk(last_exp, got_snap);
    prev_snap = got_snap;
    mon_on = 1'b1;
    rst_b <= 1'b1;
    $display("test reset values done");
    for (int c = 0; c < 3; c++) begin
      wr(c[3:0], 10'h3ff, 3);
      wr(c[3:0], 10'h001, 5);
      wr(c[3:0], 10'h155, 3);
      for (int k = 0; k < 4; k++) begin
        wr(4'(3 + c), {k[1:0], FINE_TBL[k*8 +: 8]}, 3);
      end
    end
    $display("test gain and offset done");
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_MODE_ONE, {m[2:0], m[0], m[1], m[2], ~m[0], m[2:0]}, 3);
    end
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_MODE_TWO, {m[1:0], 4'hf, ~m[1:0], m[1:0]}, 3);
    end
    $display("test mode registers done");
    i_host.send(15'h1555, 13, 3);
    i_host.send(15'h2aaa, 15, 5);
    for (int a = 8; a < 16; a++) i_host.send({1'b0, a[3:0], 10'h3ff}, 14, 3);
    drain();
    $display("test refused frames done");
    repeat (24) begin
      wr(4'($unsigned($random(seed)) % 8), 10'($random(seed)), ($random(seed) & 1) ? 5 : 3);
    end
    $display("test random writes done");
    rst_exp();
    note();
    rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    drain();
    $display("test second reset done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
